/* include/lpmc_defs.vh */
// constants for the low power mode controller
// How it works
// RULE1: sleep with select 0: clock runs, cpu halts
// RULE2: sleep keeps registers, ram, port pin levels
// RULE3: sleep ends on accepted interrupt or reset
// RULE4: sleep with select 1: stop clock, cpu, peripherals
// RULE5: standby entry freezes or initialises each peripheral
// RULE6: standby keeps state; pins hold or high impedance
// RULE7: standby ends only on nmi or reset
`ifndef LPMC_DEFS_VH
`define LPMC_DEFS_VH
// ***********************************************
// mode state codes
// ***********************************************
`define LPMC_ST_RUN 2'h0
`define LPMC_ST_SLEEP 2'h1
`define LPMC_ST_STANDBY 2'h2
`define LPMC_ST_WAKE 2'h3
// ***********************************************
// reset values and wake settle count
// ***********************************************
`define LPMC_SBY_RST 1'h0
`define LPMC_HIZ_RST 1'h0
`define LPMC_WAKE_CYC 4'h4
`endif

/* hw/lpmc_pin_hold.v */
// per pin hold or high impedance stage for port pins
`timescale 1ns/1ps
module lpmc_pin_hold #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire nrst,
  input wire freeze,
  input wire hiz_sel,
  input wire [WIDTH-1:0] hiz_mask,
  input wire [WIDTH-1:0] out_in,
  input wire [WIDTH-1:0] oe_in,
  output reg [WIDTH-1:0] out_q,
  output reg [WIDTH-1:0] oe_q
);
  // ***********************************************
  // latch last levels while frozen
  // ***********************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_q <= {WIDTH{1'b0}};
      oe_q <= {WIDTH{1'b0}};
    end else if (!freeze) begin
      out_q <= out_in;
      oe_q <= oe_in;
    end else if (hiz_sel) begin
      oe_q <= oe_q & ~hiz_mask; // [RULE6]
    end
  end
endmodule // lpmc_pin_hold

/* hw/lpmc_top.v */
// low power mode controller: sleep and standby sequencing
`timescale 1ns/1ps
`include "lpmc_defs.vh"
module lpmc_top #(
  parameter NPIN = 8,
  parameter NPER = 4
) (
  input wire clk,
  input wire nrst,
  input wire sleep_exec,
  input wire sby_wr,
  input wire sby_wdata,
  input wire hiz_wr,
  input wire hiz_wdata,
  input wire irq_accept,
  input wire nmi,
  input wire [NPER-1:0] per_init_sel,
  input wire [NPIN-1:0] pin_hiz_mask,
  input wire [NPIN-1:0] pin_out,
  input wire [NPIN-1:0] pin_oe,
  output reg standby_select_bit_q,
  output reg hiz_sel_q,
  output reg cpu_halt_q,
  output reg sys_clk_en_q,
  output reg [NPER-1:0] per_freeze_q,
  output reg [NPER-1:0] per_init_q,
  output reg in_sleep_q,
  output reg in_standby_q,
  output reg wake_nmi_q,
  output wire [NPIN-1:0] port_out_q,
  output wire [NPIN-1:0] port_oe_q
);
  // ***********************************************
  // state
  // ***********************************************
  localparam ST_RUN = `LPMC_ST_RUN;
  localparam ST_SLEEP = `LPMC_ST_SLEEP;
  localparam ST_STANDBY = `LPMC_ST_STANDBY;
  localparam ST_WAKE = `LPMC_ST_WAKE;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] wake_cnt_q;
  wire frozen;
  // ***********************************************
  // standby control register bits
  // ***********************************************
  // the cpu is halted in both low power states, so writes cannot race entry
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      standby_select_bit_q <= `LPMC_SBY_RST;
      hiz_sel_q <= `LPMC_HIZ_RST;
    end else begin
      if (sby_wr)
        standby_select_bit_q <= sby_wdata;
      if (hiz_wr)
        hiz_sel_q <= hiz_wdata;
    end
  end
  // ***********************************************
  // next state
  // ***********************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (sleep_exec && standby_select_bit_q)
          state_d = ST_STANDBY; // [RULE4]
        else if (sleep_exec)
          state_d = ST_SLEEP; // [RULE1]
      end
      ST_SLEEP: begin
        if (irq_accept || nmi)
          state_d = ST_RUN; // [RULE3]
      end
      ST_STANDBY: begin
        if (nmi)
          state_d = ST_WAKE; // [RULE7]
      end
      ST_WAKE: begin
        if (wake_cnt_q == 4'h0)
          state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end
  // ***********************************************
  // state and outputs
  // ***********************************************
  // power-on reset is nrst itself, so it always ends either state [RULE3]
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_RUN;
      wake_cnt_q <= 4'h0;
      cpu_halt_q <= 1'b0;
      sys_clk_en_q <= 1'b1;
      per_freeze_q <= {NPER{1'b0}};
      per_init_q <= {NPER{1'b0}};
      in_sleep_q <= 1'b0;
      in_standby_q <= 1'b0;
      wake_nmi_q <= 1'b0;
    end else begin
      state_q <= state_d;
      // clock restart settle time before the cpu runs again
      if (state_d == ST_WAKE && state_q != ST_WAKE)
        wake_cnt_q <= `LPMC_WAKE_CYC;
      else if (wake_cnt_q != 4'h0)
        wake_cnt_q <= wake_cnt_q - 4'h1;
      cpu_halt_q <= (state_d != ST_RUN); // [RULE1] [RULE2]
      sys_clk_en_q <= (state_d == ST_RUN) || (state_d == ST_SLEEP); // [RULE4]
      in_sleep_q <= (state_d == ST_SLEEP);
      in_standby_q <= (state_d == ST_STANDBY) || (state_d == ST_WAKE);
      // per module choice: freeze or return to initial state [RULE5]
      if (state_d == ST_STANDBY) begin
        per_freeze_q <= ~per_init_sel;
        per_init_q <= per_init_sel;
      end else begin
        per_freeze_q <= {NPER{1'b0}};
        per_init_q <= {NPER{1'b0}};
      end
      wake_nmi_q <= (state_q == ST_STANDBY) && nmi; // [RULE7]
    end
  end
  // ***********************************************
  // port pins
  // ***********************************************
  // pins frozen in both states; hi-z only allowed in standby [RULE2] [RULE6]
  assign frozen = (state_q != ST_RUN);
  lpmc_pin_hold #(
    .WIDTH(NPIN)
  ) u_pins (
    .clk(clk),
    .nrst(nrst),
    .freeze(frozen),
    .hiz_sel(hiz_sel_q && (state_q == ST_STANDBY)),
    .hiz_mask(pin_hiz_mask),
    .out_in(pin_out),
    .oe_in(pin_oe),
    .out_q(port_out_q),
    .oe_q(port_oe_q)
  );
endmodule // lpmc_top

/* tb/lpmc_props.sv */
// checker for the low power mode controller
`timescale 1ns/1ps
module lpmc_props #(parameter NPIN = 8, parameter NPER = 4) (
  input wire clk,
  input wire nrst,
  input wire sleep_exec,
  input wire irq_accept,
  input wire nmi,
  input wire [NPER-1:0] per_init_sel,
  input wire [NPIN-1:0] pin_hiz_mask,
  input wire standby_select_bit_q,
  input wire hiz_sel_q,
  input wire cpu_halt_q,
  input wire sys_clk_en_q,
  input wire [NPER-1:0] per_freeze_q,
  input wire [NPER-1:0] per_init_q,
  input wire in_sleep_q,
  input wire in_standby_q,
  input wire wake_nmi_q,
  input wire [NPIN-1:0] port_out_q,
  input wire [NPIN-1:0] port_oe_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_go; !cpu_halt_q && sleep_exec; endsequence
  property p_slp; s_go ##0 !standby_select_bit_q |=>
    in_sleep_q && cpu_halt_q && sys_clk_en_q; endproperty
  a_slp: assert property (p_slp) else $error("sleep entry");
  property p_sby; s_go ##0 standby_select_bit_q |=>
    in_standby_q && cpu_halt_q && !sys_clk_en_q; endproperty
  a_sby: assert property (p_sby) else $error("standby entry");
  property p_per; s_go ##0 standby_select_bit_q |=> per_init_q ==
    $past(per_init_sel) && per_freeze_q == ~$past(per_init_sel); endproperty
  a_per: assert property (p_per) else $error("per modes");
  property p_hold; in_sleep_q && $past(in_sleep_q) && $past(in_sleep_q, 2)
    |-> $stable(port_out_q); endproperty
  a_hold: assert property (p_hold) else $error("pins moved");
  property p_irq; in_sleep_q && irq_accept |=> !in_sleep_q; endproperty
  a_irq: assert property (p_irq) else $error("sleep exit");
  // hi-z only once peripherals settled, one edge after state
  property p_hiz; in_standby_q && hiz_sel_q && $past(|(per_freeze_q |
    per_init_q)) |-> (port_oe_q & pin_hiz_mask) == '0; endproperty
  a_hiz: assert property (p_hiz) else $error("hi-z pins");
  property p_stay; (in_standby_q && !nmi) [*7] |=> in_standby_q; endproperty
  a_stay: assert property (p_stay) else $error("left standby");
  property p_nmi; wake_nmi_q |-> ##[1:8] !cpu_halt_q; endproperty
  a_nmi: assert property (p_nmi) else $error("no wake");
endmodule // lpmc_props

/* tb/lpmc_top_tb_top.sv */
// self-checking bench for the low power mode controller
`timescale 1ns/1ps
module lpmc_top_tb_top;
  logic clk = 0, nrst = 0, sleep_exec = 0, sby_wr = 0, sby_wdata = 0;
  logic hiz_wr = 0, hiz_wdata = 0, irq_accept = 0, nmi = 0, smp = 0;
  logic [3:0] per_init_sel = 4'h0;
  logic [7:0] pin_hiz_mask = 8'h0, pin_out = 8'h0, pin_oe = 8'h0;
  logic [31:0] seed = 32'h6855319B;
  logic [7:0] p0, p1, m;
  logic [19:0] exp_q[$];
  wire halt, clk_en, slp, standby_select_bit;
  wire [7:0] pout, poe;
  int failures = 0, checks = 0;
  always #4 clk = ~clk;
  lpmc_top lpmc_top_i (.clk(clk), .nrst(nrst), .sleep_exec(sleep_exec),
    .sby_wr(sby_wr), .sby_wdata(sby_wdata), .hiz_wr(hiz_wr),
    .hiz_wdata(hiz_wdata), .irq_accept(irq_accept), .nmi(nmi),
    .per_init_sel(per_init_sel), .pin_hiz_mask(pin_hiz_mask),
    .pin_out(pin_out), .pin_oe(pin_oe), .standby_select_bit_q(),
    .hiz_sel_q(), .cpu_halt_q(halt), .sys_clk_en_q(clk_en),
    .per_freeze_q(), .per_init_q(), .in_sleep_q(slp),
    .in_standby_q(standby_select_bit), .wake_nmi_q(), .port_out_q(pout),
    .port_oe_q(poe));
  function logic [31:0] xs;
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction
  task give_verdict;
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [19:0] seen, input logic [19:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // note {halt, clk_en, sleep, standby, pins, oe}, seen at next negedge
  task go(input logic [19:0] e);
    exp_q.push_back(e); smp <= 1; @(posedge clk); smp <= 0;
  endtask
  // 0 sleep, 1 hiz write, 2 select write, 3 irq, else nmi
  task automatic pulse(input int k);
    case (k)
      0: sleep_exec <= 1;
      1: hiz_wr <= 1;
      2: sby_wr <= 1;
      3: irq_accept <= 1;
      default: nmi <= 1;
    endcase
    @(posedge clk);
    case (k)
      0: sleep_exec <= 0;
      1: hiz_wr <= 0;
      2: sby_wr <= 0;
      3: irq_accept <= 0;
      default: nmi <= 0;
    endcase
  endtask
  // wake settle length is the design's, so wait bounded
  task wt;
    int i;
    for (i = 0; i < 20 && halt !== 0; i++) @(negedge clk);
    if (i == 20) begin failures++; give_verdict; end
    @(posedge clk);
  endtask
  always @(negedge clk) if (smp) begin
    chk({halt, clk_en, slp, standby_select_bit, pout, poe}, exp_q[0]);
    void'(exp_q.pop_front());
  end
  initial begin
    repeat (4) @(posedge clk);
    p0 = xs(); p1 = xs(); m = xs();
    nrst <= 1; per_init_sel <= xs(); pin_hiz_mask <= m;
    pin_out <= p0; pin_oe <= 8'hFF; hiz_wdata <= 1; pulse(1);
    pulse(0); go({4'hE, p0, 8'hFF});
    pin_out <= p1; repeat (3) @(posedge clk);
    go({4'hE, p0, 8'hFF});
    pulse(3); wt; go({4'h4, p1, 8'hFF});
    sby_wdata <= 1; pulse(2); pulse(0); go({4'h9, p1, 8'hFF});
    pulse(3); repeat (8) @(posedge clk); go({4'h9, p1, ~m});
    pulse(4); wt; go({4'h4, p1, 8'hFF});
    repeat (2) @(posedge clk);
    give_verdict;
  end
endmodule // lpmc_top_tb_top
bind lpmc_top lpmc_props #(.NPIN(NPIN), .NPER(NPER)) lpmc_props_i (.*);
